// ==== design/buck_seq_pkg.sv ====
// Constants and types for the two-channel buck start-up and protection sequencer.
// Assumes a single 125 MHz timebase; all counts derive from it.
package buck_seq_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Structure
    localparam int NUM_CH = 2;
    localparam int PH_PER_CH = 2;
    localparam int NUM_PH = NUM_CH * PH_PER_CH;
    localparam int CNT_W = 24;
    localparam int DEB_W = 8;
    localparam int DELAY_CODE_W = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Timebase
    localparam int CLK_PERIOD_NS = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Times in their own units
    localparam int OV_DEBOUNCE_NS = 1000;
    localparam int UV_DEBOUNCE_NS = 1500;
    localparam int NEG_OFF_NS = 50;
    localparam int RESET_PERIOD_US = 100;
    localparam int DELAY_STEP_US = 100;
    localparam int PG_DELAY_US = 1000;
    localparam int HICCUP_US = 10000;

    ////////////////////////////////////////////////////////////////////////////
    // Cycle counts; least times round up
    localparam int OV_DEB_CYC = (OV_DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int UV_DEB_CYC = (UV_DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NEG_OFF_CYC = (NEG_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_CYC = (RESET_PERIOD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DELAY_STEP_CYC = (DELAY_STEP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PG_DELAY_CYC = (PG_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HICCUP_CYC = (HICCUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////////
    // Overcurrent hiccup: more than this many consecutive all-phase trips
    localparam int OC_CYCLE_LIMIT = 8;
    localparam int OC_CNT_W = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic MEM_MODE_RST = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Per-channel sequencer states
    typedef enum logic [6:0] {
        ST_OFF    = 7'b0000001,
        ST_RESET  = 7'b0000010,
        ST_DELAY  = 7'b0000100,
        ST_SOFT   = 7'b0001000,
        ST_PGWAIT = 7'b0010000,
        ST_RUN    = 7'b0100000,
        ST_HICCUP = 7'b1000000
    } seq_state_t;

endpackage

// ==== design/buck_protection_sequencer.sv ====
// Start-up and protection sequencer for a two-channel, two-phase-per-channel buck.
// Assumes comparator and modulator inputs are synchronous to ref_clk_i.
`timescale 1ns/10ps

module buck_protection_sequencer #(
    parameter logic [23:0] RESET_CYC = 24'(buck_seq_pkg::RESET_CYC),
    parameter logic [23:0] DELAY_STEP_CYC = 24'(buck_seq_pkg::DELAY_STEP_CYC),
    parameter logic [23:0] PG_DELAY_CYC = 24'(buck_seq_pkg::PG_DELAY_CYC),
    parameter logic [23:0] HICCUP_CYC = 24'(buck_seq_pkg::HICCUP_CYC)
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    input wire logic [1:0] enable_i,
    input wire logic internal_supply_ok_i,
    input wire logic power_stage_ready_i,
    input wire logic delay_two_memory_select_i,
    input wire logic [2:0] channel_one_delay_pin_i,
    input wire logic [2:0] channel_two_delay_code_i,
    input wire logic [1:0] soft_start_done_i,
    input wire logic [1:0] ramp_reached_output_i,
    input wire logic [1:0] overvoltage_level_one_i,
    input wire logic [1:0] overvoltage_level_two_i,
    input wire logic [1:0] overvoltage_clear_i,
    input wire logic [1:0] undervoltage_trip_i,
    input wire logic [3:0] pwm_request_i,
    input wire logic [3:0] cycle_start_i,
    input wire logic [3:0] peak_current_i,
    input wire logic [3:0] negative_current_i,
    output logic [3:0] high_side_on_o,
    output logic [3:0] low_side_on_o,
    output logic [1:0] power_good_out_o,
    output logic [1:0] soft_start_run_o,
    output logic [1:0] hiccup_active_o,
    output logic memory_mode_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Shared signals

    logic mem_mode_r;
    logic [1:0] off_vec;
    logic [1:0] active_vec;
    logic [1:0] hiccup_req_vec;
    logic [1:0] ovl_vec;
    logic [1:0] ovh_vec;
    logic [1:0] prebias_ok_vec;
    logic [1:0] oc_mon_vec;

    function automatic logic [23:0] delay_cycles(input logic [2:0] code);
        delay_cycles = 24'(code * DELAY_STEP_CYC);
    endfunction

    // Pin sampled only while both channels sit idle
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            mem_mode_r <= buck_seq_pkg::MEM_MODE_RST;
        end else if (clk_en_i && (&off_vec)) begin
            mem_mode_r <= delay_two_memory_select_i;
        end
    end

    assign memory_mode_o = mem_mode_r;

    ////////////////////////////////////////////////////////////////////////////
    // Per-channel sequencing and voltage protection

    genvar c;
    generate
        for (c = 0; c < buck_seq_pkg::NUM_CH; c = c + 1) begin : g_ch
            buck_seq_pkg::seq_state_t state_r;
            logic [23:0] cnt_r;
            logic [7:0] ovl_deb_r;
            logic [7:0] ovh_deb_r;
            logic [7:0] uv_deb_r;
            logic [3:0] oc_cnt_r;
            logic ovl_state_r;
            logic ovh_state_r;
            logic prebias_ok_r;
            logic pg_r;
            logic ss_run_r;
            logic hiccup_r;
            logic can_start;
            logic active;
            logic ovh_mon;
            logic run_mon;
            logic ovl_trip;
            logic ovh_trip;
            logic uv_trip;
            logic oc_trip;
            logic own_req;
            logic hiccup_go;
            logic [2:0] delay_code;
            logic [1:0] all_tripped;

            assign can_start = enable_i[c] & internal_supply_ok_i & power_stage_ready_i;
            assign active = (state_r == buck_seq_pkg::ST_SOFT) ||
                            (state_r == buck_seq_pkg::ST_PGWAIT) ||
                            (state_r == buck_seq_pkg::ST_RUN);
            assign ovh_mon = active;
            assign run_mon = (state_r == buck_seq_pkg::ST_RUN);
            assign ovl_trip = run_mon && overvoltage_level_one_i[c] &&
                              (ovl_deb_r == 8'(buck_seq_pkg::OV_DEB_CYC));
            assign ovh_trip = ovh_mon && overvoltage_level_two_i[c] &&
                              (ovh_deb_r == 8'(buck_seq_pkg::OV_DEB_CYC));
            assign uv_trip = run_mon && undervoltage_trip_i[c] &&
                             (uv_deb_r == 8'(buck_seq_pkg::UV_DEB_CYC));
            assign oc_trip = (oc_cnt_r > 4'(buck_seq_pkg::OC_CYCLE_LIMIT));
            assign own_req = uv_trip | oc_trip;
            assign hiccup_go = hiccup_req_vec[c] | (mem_mode_r & hiccup_req_vec[1 - c]);
            assign delay_code = mem_mode_r ? channel_one_delay_pin_i :
                                ((c == 0) ? channel_one_delay_pin_i : channel_two_delay_code_i);

            assign hiccup_req_vec[c] = own_req;
            assign off_vec[c] = (state_r == buck_seq_pkg::ST_OFF);
            assign active_vec[c] = active;
            assign ovl_vec[c] = ovl_state_r;
            assign ovh_vec[c] = ovh_state_r;
            assign prebias_ok_vec[c] = prebias_ok_r;
            assign oc_mon_vec[c] = active;
            assign power_good_out_o[c] = pg_r;
            assign soft_start_run_o[c] = ss_run_r;
            assign hiccup_active_o[c] = hiccup_r;

            // Sequencer
            always_ff @(posedge ref_clk_i) begin
                if (reset_i) begin
                    state_r <= buck_seq_pkg::ST_OFF;
                    cnt_r <= 24'h000000;
                end else if (clk_en_i) begin
                    if (!can_start) begin
                        state_r <= buck_seq_pkg::ST_OFF;
                        cnt_r <= 24'h000000;
                    end else if (hiccup_go && (state_r != buck_seq_pkg::ST_OFF) &&
                                 (state_r != buck_seq_pkg::ST_HICCUP)) begin
                        state_r <= buck_seq_pkg::ST_HICCUP;
                        cnt_r <= HICCUP_CYC;
                    end else begin
                        case (state_r)
                            buck_seq_pkg::ST_OFF: begin
                                state_r <= buck_seq_pkg::ST_RESET;
                                cnt_r <= RESET_CYC;
                            end
                            buck_seq_pkg::ST_RESET: begin
                                if (cnt_r == 24'h000000) begin
                                    state_r <= buck_seq_pkg::ST_DELAY;
                                    cnt_r <= delay_cycles(delay_code);
                                end else begin
                                    cnt_r <= cnt_r - 24'h000001;
                                end
                            end
                            buck_seq_pkg::ST_DELAY: begin
                                if (cnt_r == 24'h000000) begin
                                    state_r <= buck_seq_pkg::ST_SOFT;
                                end else begin
                                    cnt_r <= cnt_r - 24'h000001;
                                end
                            end
                            buck_seq_pkg::ST_SOFT: begin
                                if (soft_start_done_i[c]) begin
                                    state_r <= buck_seq_pkg::ST_PGWAIT;
                                    cnt_r <= PG_DELAY_CYC;
                                end
                            end
                            buck_seq_pkg::ST_PGWAIT: begin
                                if (cnt_r == 24'h000000) begin
                                    state_r <= buck_seq_pkg::ST_RUN;
                                end else begin
                                    cnt_r <= cnt_r - 24'h000001;
                                end
                            end
                            buck_seq_pkg::ST_RUN: begin
                                state_r <= buck_seq_pkg::ST_RUN;
                            end
                            buck_seq_pkg::ST_HICCUP: begin
                                if (cnt_r == 24'h000000) begin
                                    state_r <= buck_seq_pkg::ST_RESET;
                                    cnt_r <= RESET_CYC;
                                end else begin
                                    cnt_r <= cnt_r - 24'h000001;
                                end
                            end
                            default: begin
                                state_r <= buck_seq_pkg::ST_OFF;
                                cnt_r <= 24'h000000;
                            end
                        endcase
                    end
                end
            end

            // Debounce counters, saturating at their trip count
            always_ff @(posedge ref_clk_i) begin
                if (reset_i) begin
                    ovl_deb_r <= 8'h00;
                    ovh_deb_r <= 8'h00;
                    uv_deb_r <= 8'h00;
                end else if (clk_en_i) begin
                    if (run_mon && overvoltage_level_one_i[c]) begin
                        if (ovl_deb_r != 8'(buck_seq_pkg::OV_DEB_CYC)) begin
                            ovl_deb_r <= ovl_deb_r + 8'h01;
                        end
                    end else begin
                        ovl_deb_r <= 8'h00;
                    end
                    if (ovh_mon && overvoltage_level_two_i[c]) begin
                        if (ovh_deb_r != 8'(buck_seq_pkg::OV_DEB_CYC)) begin
                            ovh_deb_r <= ovh_deb_r + 8'h01;
                        end
                    end else begin
                        ovh_deb_r <= 8'h00;
                    end
                    if (run_mon && undervoltage_trip_i[c]) begin
                        if (uv_deb_r != 8'(buck_seq_pkg::UV_DEB_CYC)) begin
                            uv_deb_r <= uv_deb_r + 8'h01;
                        end
                    end else begin
                        uv_deb_r <= 8'h00;
                    end
                end
            end

            // Recoverable overvoltage levels
            always_ff @(posedge ref_clk_i) begin
                if (reset_i) begin
                    ovl_state_r <= 1'b0;
                    ovh_state_r <= 1'b0;
                end else if (clk_en_i) begin
                    if (!ovh_mon) begin
                        ovl_state_r <= 1'b0;
                        ovh_state_r <= 1'b0;
                    end else if (ovh_trip) begin
                        ovl_state_r <= 1'b0;
                        ovh_state_r <= 1'b1;
                    end else if (overvoltage_clear_i[c]) begin
                        ovl_state_r <= 1'b0;
                        ovh_state_r <= 1'b0;
                    end else if (ovl_trip && !ovh_state_r) begin
                        ovl_state_r <= 1'b1;
                    end
                end
            end

            // Consecutive all-phase current limit cycles
            assign all_tripped = peak_current_i[2 * c +: 2] | g_ph_flag[c].trip_pair;
            always_ff @(posedge ref_clk_i) begin
                if (reset_i) begin
                    oc_cnt_r <= 4'h0;
                end else if (clk_en_i) begin
                    if (!oc_mon_vec[c]) begin
                        oc_cnt_r <= 4'h0;
                    end else if (cycle_start_i[2 * c]) begin
                        if (&all_tripped) begin
                            if (!oc_trip) begin
                                oc_cnt_r <= oc_cnt_r + 4'h1;
                            end
                        end else begin
                            oc_cnt_r <= 4'h0;
                        end
                    end
                end
            end

            // Status outputs and pre-bias tracking
            always_ff @(posedge ref_clk_i) begin
                if (reset_i) begin
                    prebias_ok_r <= 1'b0;
                    pg_r <= 1'b0;
                    ss_run_r <= 1'b0;
                    hiccup_r <= 1'b0;
                end else if (clk_en_i) begin
                    if (!active) begin
                        prebias_ok_r <= 1'b0;
                    end else if (ramp_reached_output_i[c]) begin
                        prebias_ok_r <= 1'b1;
                    end
                    pg_r <= run_mon && !ovl_state_r && !ovh_state_r && !ovl_trip &&
                            !ovh_trip && !uv_trip && !hiccup_go;
                    ss_run_r <= active && !hiccup_go;
                    hiccup_r <= (state_r == buck_seq_pkg::ST_HICCUP);
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Per-channel pair of latched peak trips, read by the overcurrent counter

    generate
        for (c = 0; c < buck_seq_pkg::NUM_CH; c = c + 1) begin : g_ph_flag
            logic [1:0] trip_pair;
            assign trip_pair = {g_ph[2 * c + 1].trip_r, g_ph[2 * c].trip_r};
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Per-phase switch commands

    genvar p;
    generate
        for (p = 0; p < buck_seq_pkg::NUM_PH; p = p + 1) begin : g_ph
            localparam int CH = p / buck_seq_pkg::PH_PER_CH;
            logic trip_r;
            logic [2:0] neg_cnt_r;
            logic hs_r;
            logic ls_r;
            logic neg_block;

            assign neg_block = negative_current_i[p] || (neg_cnt_r != 3'h0);
            assign high_side_on_o[p] = hs_r;
            assign low_side_on_o[p] = ls_r;

            // Peak trip holds until the phase's next cycle; a new trip wins
            always_ff @(posedge ref_clk_i) begin
                if (reset_i) begin
                    trip_r <= 1'b0;
                end else if (clk_en_i) begin
                    trip_r <= peak_current_i[p] | (trip_r & ~cycle_start_i[p]);
                end
            end

            // Low-side off window after a negative current event in level-one overvoltage
            always_ff @(posedge ref_clk_i) begin
                if (reset_i) begin
                    neg_cnt_r <= 3'h0;
                end else if (clk_en_i) begin
                    if (ovl_vec[CH] && negative_current_i[p]) begin
                        neg_cnt_r <= 3'(buck_seq_pkg::NEG_OFF_CYC);
                    end else if (neg_cnt_r != 3'h0) begin
                        neg_cnt_r <= neg_cnt_r - 3'h1;
                    end
                end
            end

            always_ff @(posedge ref_clk_i) begin
                if (reset_i) begin
                    hs_r <= 1'b0;
                    ls_r <= 1'b0;
                end else if (clk_en_i) begin
                    if (!active_vec[CH] || hiccup_req_vec[CH]) begin
                        hs_r <= 1'b0;
                        ls_r <= 1'b0;
                    end else if (ovh_vec[CH]) begin
                        hs_r <= 1'b0;
                        ls_r <= 1'b1;
                    end else if (ovl_vec[CH]) begin
                        hs_r <= 1'b0;
                        ls_r <= !neg_block;
                    end else begin
                        hs_r <= pwm_request_i[p] && !peak_current_i[p] &&
                                !(trip_r && !cycle_start_i[p]);
                        ls_r <= !pwm_request_i[p] && prebias_ok_vec[CH];
                    end
                end
            end
        end
    endgenerate

endmodule

// ==== verif/stage_model.sv ====
// Behavioural model of the per-phase driver and switch stages.
// Assumes commands from the sequencer on the same clock.
`timescale 1ns/10ps
module stage_model (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [3:0] low_side_on_i,
    input wire logic sink_i,
    output logic ready_o,
    output logic [3:0] neg_current_o = 4'h0
);
    logic [3:0] wake_r = 4'h0;
    assign ready_o = (wake_r == 4'hf);
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wake_r <= 4'h0;
        end else if (!ready_o) begin
            wake_r <= wake_r + 4'h1;
        end
    end
    // Reverse current through a closed low side
    always_ff @(posedge clk_i) begin
        neg_current_o <= low_side_on_i & {4{sink_i}};
    end
endmodule

// ==== verif/buck_seq_chk.sv ====
// Port assertions for the buck sequencer.
// Assumes clk_en_i held high; bound to the design at the foot.
`timescale 1ns/10ps
module buck_seq_chk #(
    parameter logic [23:0] RESET_CYC = 24'h8
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [1:0] enable_i,
    input wire logic [1:0] ramp_reached_output_i,
    input wire logic [1:0] overvoltage_level_one_i,
    input wire logic [1:0] overvoltage_level_two_i,
    input wire logic [1:0] overvoltage_clear_i,
    input wire logic [1:0] undervoltage_trip_i,
    input wire logic [3:0] peak_current_i,
    input wire logic [3:0] high_side_on_o,
    input wire logic [3:0] low_side_on_o,
    input wire logic [1:0] power_good_out_o,
    input wire logic [1:0] soft_start_run_o,
    input wire logic [1:0] hiccup_active_o,
    input wire logic memory_mode_o
);
    logic [23:0] en_n_r;
    logic [8:0] uv_n_r, ov1_n_r, ov2_n_r;
    wire uv_go = undervoltage_trip_i[0] && (power_good_out_o[0] || uv_n_r != 9'h0);
    wire ov1_go = overvoltage_level_one_i[0] && !overvoltage_clear_i[0]
        && (power_good_out_o[0] || ov1_n_r != 9'h0);
    wire ov2_go = overvoltage_level_two_i[0] && !overvoltage_clear_i[0]
        && enable_i[0] && soft_start_run_o[0];
    function automatic logic [8:0] inc(input logic [8:0] v);
        return v + 9'(v != 9'h1ff);
    endfunction
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    ////////////////////////////////////////////////////////////////////////////
    // Runs of qualified samples, saturating
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            en_n_r <= 24'h0;
            uv_n_r <= 9'h0;
            ov1_n_r <= 9'h0;
            ov2_n_r <= 9'h0;
        end else begin
            en_n_r <= enable_i[0] ? en_n_r + 24'(en_n_r != 24'hffffff) : 24'h0;
            uv_n_r <= uv_go ? inc(uv_n_r) : 9'h0;
            ov1_n_r <= ov1_go ? inc(ov1_n_r) : 9'h0;
            ov2_n_r <= ov2_go ? inc(ov2_n_r) : 9'h0;
        end
    end
    sequence s_dry_start;
        $rose(soft_start_run_o[0]) ##0 !ramp_reached_output_i[0];
    endsequence
    sequence s_pair_hiccup;
        memory_mode_o && enable_i == 2'b11 && $rose(|hiccup_active_o);
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    a_ramp_after_reset: assert property ($rose(soft_start_run_o[0]) |-> en_n_r > RESET_CYC)
        else $error("ramp began too early");
    a_off_when_disabled: assert property (!enable_i[0] [*2] |=> !soft_start_run_o[0]
        && !power_good_out_o[0] && high_side_on_o[1:0] == 2'b00) else $error("not off");
    a_prebias_low_off: assert property (s_dry_start |=> low_side_on_o[1:0] == 2'b00)
        else $error("low side on before ramp");
    a_peak_ends_on: assert property (peak_current_i[0] |=> !high_side_on_o[0])
        else $error("high side on after peak");
    a_ov_one_good: assert property (ov1_n_r == 9'h7e |-> !power_good_out_o[0])
        else $error("good kept in overvoltage");
    a_ov_two_switch: assert property (ov2_n_r == 9'h82 |-> high_side_on_o[1:0] == 2'b00
        && (hiccup_active_o[0] || low_side_on_o[1:0] == 2'b11)) else $error("switches wrong");
    a_uv_trip_off: assert property (uv_n_r == 9'hc8 |-> !power_good_out_o[0]
        && (high_side_on_o[1:0] | low_side_on_o[1:0]) == 2'b00) else $error("uv not tripped");
    a_hiccup_all_off: assert property (hiccup_active_o[0] [*2] |->
        (high_side_on_o[1:0] | low_side_on_o[1:0]) == 2'b00) else $error("switch in hiccup");
    a_mem_hiccup_both: assert property (s_pair_hiccup |-> ##[0:2] hiccup_active_o == 2'b11)
        else $error("hiccup not paired");
endmodule

bind buck_protection_sequencer buck_seq_chk #(.RESET_CYC(RESET_CYC)) buck_seq_chk_i (
    .ref_clk_i, .reset_i, .enable_i, .ramp_reached_output_i, .overvoltage_level_one_i,
    .overvoltage_level_two_i, .overvoltage_clear_i, .undervoltage_trip_i, .peak_current_i,
    .high_side_on_o, .low_side_on_o, .power_good_out_o, .soft_start_run_o, .hiccup_active_o,
    .memory_mode_o
);

// ==== verif/buck_protection_sequencer_tb.sv ====
// Self-checking bench for the buck sequencer.
// Assumes the stage model and the bound checker are compiled with it.
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module buck_protection_sequencer_tb;
    logic ref_clk_i = 1'b0, reset_i = 1'b1, clk_en_i = 1'b1, internal_supply_ok_i = 1'b1;
    logic delay_two_memory_select_i = 1'b0, sink = 1'b0, power_stage_ready_i, memory_mode_o;
    logic [1:0] enable_i, soft_start_done_i, ramp_reached_output_i, overvoltage_level_one_i;
    logic [1:0] overvoltage_level_two_i, overvoltage_clear_i, undervoltage_trip_i;
    logic [1:0] power_good_out_o, soft_start_run_o, hiccup_active_o;
    logic [2:0] channel_one_delay_pin_i = 3'h1, channel_two_delay_code_i = 3'h3;
    logic [3:0] pwm_request_i, cycle_start_i, peak_current_i, negative_current_i;
    logic [3:0] high_side_on_o, low_side_on_o;
    logic [3:0] q[$];
    int failures = 0, compares = 0, t0;
    buck_protection_sequencer #(.RESET_CYC(24'h8), .DELAY_STEP_CYC(24'h4),
        .PG_DELAY_CYC(24'h10), .HICCUP_CYC(24'h20)) buck_protection_sequencer_i (
        .ref_clk_i, .reset_i, .clk_en_i, .enable_i, .internal_supply_ok_i, .power_stage_ready_i,
        .delay_two_memory_select_i, .channel_one_delay_pin_i, .channel_two_delay_code_i,
        .soft_start_done_i, .ramp_reached_output_i, .overvoltage_level_one_i,
        .overvoltage_level_two_i, .overvoltage_clear_i, .undervoltage_trip_i, .pwm_request_i,
        .cycle_start_i, .peak_current_i, .negative_current_i, .high_side_on_o, .low_side_on_o,
        .power_good_out_o, .soft_start_run_o, .hiccup_active_o, .memory_mode_o);
    stage_model stage_model_i (.clk_i(ref_clk_i), .reset_i, .low_side_on_i(low_side_on_o),
        .sink_i(sink), .ready_o(power_stage_ready_i), .neg_current_o(negative_current_i));
    always #4 ref_clk_i = ~ref_clk_i;
    ////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    function automatic logic pick(input int s);
        logic [5:0] v;
        v = {hiccup_active_o, power_good_out_o, soft_start_run_o};
        return v[s];
    endfunction
    task automatic await(input int s, input logic v, output int n);
        n = 0;
        while (pick(s) !== v && n < 400) begin
            cyc(1);
            n++;
        end
        `CHK(pick(s), v)
    endtask
    task automatic ov_clear();
        {sink, overvoltage_level_one_i, overvoltage_level_two_i} = 5'h0;
        overvoltage_clear_i = 2'b01;
        cyc(12);
        `CHK({hiccup_active_o[0], high_side_on_o[1:0]}, 3'h3)
        overvoltage_clear_i = 2'b00;
    endtask
    task automatic conclude();
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        cyc(8000);
        failures++;
        $display("mismatch at %0t: run hung", $time);
        conclude();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {enable_i, soft_start_done_i, ramp_reached_output_i, overvoltage_level_one_i,
            overvoltage_level_two_i, overvoltage_clear_i, undervoltage_trip_i} = 14'h0;
        {pwm_request_i, cycle_start_i, peak_current_i} = 12'h0;
        void'($urandom(32'hfd69));
        cyc(3);
        reset_i = 1'b0;
        while (!power_stage_ready_i) cyc(1);
        enable_i = 2'b11;
        await(0, 1'b1, t0);
        `CHK(t0 >= 12, 1'b1)
        await(1, 1'b1, t0);
        `CHK(t0, 8)
        cyc(1);
        `CHK(low_side_on_o, 4'h0)
        ramp_reached_output_i = 2'b11;
        cyc(1);
        for (int i = 0; i < 24; i++) begin
            pwm_request_i = 4'($urandom);
            q.push_back(pwm_request_i);
            cyc(1);
            `CHK(high_side_on_o, q[0])
            `CHK(low_side_on_o, ~q.pop_front())
        end
        pwm_request_i = 4'hf;
        peak_current_i = 4'h5;
        cyc(1);
        `CHK(high_side_on_o, 4'ha)
        peak_current_i = 4'h0;
        cycle_start_i = 4'hf;
        cyc(1);
        cycle_start_i = 4'h0;
        cyc(1);
        `CHK(high_side_on_o, 4'hf)
        soft_start_done_i = 2'b11;
        await(2, 1'b1, t0);
        `CHK(t0 >= 16, 1'b1)
        sink = 1'b1;
        overvoltage_level_two_i = 2'b01;
        cyc(130);
        `CHK({power_good_out_o[0], high_side_on_o[1:0], low_side_on_o[1:0]}, 5'h03)
        ov_clear();
        overvoltage_level_one_i = 2'b01;
        cyc(130);
        `CHK({power_good_out_o[0], low_side_on_o[1:0]}, 3'h3)
        sink = 1'b1;
        cyc(2);
        `CHK(low_side_on_o[1:0], 2'b00)
        cyc(5);
        `CHK(low_side_on_o[1:0], 2'b00)
        ov_clear();
        peak_current_i = 4'hc;
        for (int i = 1; i <= 9; i++) begin
            cycle_start_i = 4'hc;
            cyc(1);
            cycle_start_i = 4'h0;
            cyc(3);
            if (i >= 8) `CHK(hiccup_active_o[1], 1'(i == 9))
        end
        peak_current_i = 4'h0;
        await(5, 1'b0, t0);
        `CHK(t0 >= 28, 1'b1)
        await(1, 1'b1, t0);
        undervoltage_trip_i = 2'b01;
        cyc(200);
        `CHK({power_good_out_o[0], hiccup_active_o[0], high_side_on_o[1:0]}, 4'h4)
        undervoltage_trip_i = 2'b00;
        await(0, 1'b1, t0);
        `CHK(t0 > 20, 1'b1)
        reset_i = 1'b1;
        enable_i = 2'b00;
        {internal_supply_ok_i, delay_two_memory_select_i} = 2'b01;
        channel_two_delay_code_i = 3'h5;
        cyc(3);
        reset_i = 1'b0;
        enable_i = 2'b11;
        cyc(40);
        `CHK({memory_mode_o, soft_start_run_o}, 3'h4)
        internal_supply_ok_i = 1'b1;
        await(0, 1'b1, t0);
        `CHK(soft_start_run_o, 2'b11)
        await(2, 1'b1, t0);
        undervoltage_trip_i = 2'b10;
        cyc(200);
        `CHK(hiccup_active_o, 2'b11)
        conclude();
    end
endmodule
